// ---- mahpmr_regs.sv ----
/*
  Station address, multicast hash table and PHY management access
  registers, with the power-on address load and the management frame
  engine. Assumes a word-indexed register port, a byte-wide
  configuration memory reader, and a tri-state management data pin.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - upper address in bits 15-0, resets 0000ffff
// - lower address full word, resets 0fffffff
// - load addresses only if memory programmed
// - bytes 01-04 fill lower, lsb first
// - byte 05 upper 7:0, 06 upper 15:8
// - lower byte 0 is first octet
// - six bit index, top picks half
// - 000000 low bit0, 111111 high bit31
// - group frame accepted when bit set
// - pass-all accepts every group frame
// - high/low hash halves, reset zero
// - bits 10-6 select phy register
// - bit 1 write, else read into data
// - busy set by host, cleared at end
// - read data valid after busy clears
// - data register bits 15-0, rest zero
module mahpmr_regs (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  input  wire logic [3:0]                     addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output var  logic [31:0]                    rdata,
  input  wire logic                           cfg_present,
  output var  logic                           cfg_req,
  output var  logic [7:0]                     cfg_addr,
  input  wire logic                           cfg_ack,
  input  wire logic [7:0]                     cfg_data,
  output var  logic                           load_done,
  output var  logic                           mdc,
  input  wire logic                           mdio_in,
  output var  logic                           mdio_out,
  output var  logic                           mdio_oe_n,
  input  wire mahpmr_pkg::mahpmr_rx_addr_type rx_addr,
  output var  mahpmr_pkg::mahpmr_filter_type  filt
);

  logic [31:0]                     station_address_upper;
  logic [31:0]                     station_address_lower;
  logic [31:0]                     multicast_hash_upper;
  logic [31:0]                     multicast_hash_lower;
  logic [31:0]                     phy_management_access;
  logic [15:0]                     phy_data;
  logic                            pass_all_group_frames;
  mahpmr_pkg::mahpmr_ld_state_type ld_state;
  mahpmr_pkg::mahpmr_mg_state_type mg_state;
  mahpmr_pkg::mahpmr_hash_type     hash;
  logic [1:0]                      div_cnt;
  logic [5:0]                      bit_cnt;
  logic [63:0]                     frame_sr;
  logic [15:0]                     rd_sr;
  logic                            acc_start;
  logic                            mg_read;
  logic                            ld_take;

  assign mg_read   = ~phy_management_access[mahpmr_pkg::ACC_DIR_BIT];
  assign acc_start = wr && ce && addr == mahpmr_pkg::OFF_ACC && mg_state == mahpmr_pkg::MG_IDLE
                     && wdata[mahpmr_pkg::ACC_BUSY_BIT];
  assign ld_take   = ce && ld_state == mahpmr_pkg::LD_FETCH && cfg_ack;

  // ----------------------------------------------------------------------
  // power-on address load
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ld_state  <= mahpmr_pkg::LD_CHECK;
      cfg_req   <= 1'b0;
      cfg_addr  <= mahpmr_pkg::CFG_FIRST;
      load_done <= 1'b0;
    end else if (ce) begin
      case (ld_state)
        mahpmr_pkg::LD_CHECK: begin
          if (cfg_present) begin
            ld_state <= mahpmr_pkg::LD_FETCH;
            cfg_req  <= 1'b1;
          end else begin
            ld_state  <= mahpmr_pkg::LD_DONE;
            load_done <= 1'b1;
          end
        end
        mahpmr_pkg::LD_FETCH: begin
          if (cfg_ack) begin
            if (cfg_addr == mahpmr_pkg::CFG_LAST) begin
              ld_state  <= mahpmr_pkg::LD_DONE;
              cfg_req   <= 1'b0;
              load_done <= 1'b1;
            end else begin
              cfg_addr <= cfg_addr + 8'h01;
            end
          end
        end
        mahpmr_pkg::LD_DONE: begin
          cfg_req <= 1'b0;
        end
        default: begin
          ld_state <= mahpmr_pkg::LD_CHECK;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // station address
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      station_address_upper <= mahpmr_pkg::RST_ADDRU;
      station_address_lower <= mahpmr_pkg::RST_STATION_ADDRESS_LOWER;
    end else if (ld_take) begin
      case (cfg_addr)
        8'h01:   station_address_lower[7:0]   <= cfg_data;
        8'h02:   station_address_lower[15:8]  <= cfg_data;
        8'h03:   station_address_lower[23:16] <= cfg_data;
        8'h04:   station_address_lower[31:24] <= cfg_data;
        8'h05:   station_address_upper[7:0]   <= cfg_data;
        8'h06:   station_address_upper[15:8]  <= cfg_data;
        default: station_address_upper[15:8]  <= station_address_upper[15:8];
      endcase
    end else if (wr && ce && load_done) begin
      if (addr == mahpmr_pkg::OFF_ADDRU) begin
        station_address_upper <= {16'h0000, wdata[15:0]};
      end
      if (addr == mahpmr_pkg::OFF_STATION_ADDRESS_LOWER) begin
        station_address_lower <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // hash table and control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      multicast_hash_upper  <= mahpmr_pkg::RST_HASH;
      multicast_hash_lower  <= mahpmr_pkg::RST_HASH;
      pass_all_group_frames <= 1'b0;
    end else if (wr && ce) begin
      if (addr == mahpmr_pkg::OFF_HASHU) begin
        multicast_hash_upper <= wdata;
      end
      if (addr == mahpmr_pkg::OFF_MULTICAST_HASH_LOWER) begin
        multicast_hash_lower <= wdata;
      end
      if (addr == mahpmr_pkg::OFF_CTRL) begin
        pass_all_group_frames <= wdata[mahpmr_pkg::CTRL_PASS_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // management access and data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      phy_management_access <= mahpmr_pkg::RST_ACC;
    end else if (ce) begin
      if (acc_start) begin
        phy_management_access <= {16'h0000, wdata[15:6], 4'h0, wdata[1:0]};
      end else if (wr && addr == mahpmr_pkg::OFF_ACC && mg_state == mahpmr_pkg::MG_IDLE) begin
        phy_management_access <= {16'h0000, wdata[15:6], 4'h0, wdata[1], 1'b0};
      end else if (mg_state == mahpmr_pkg::MG_END) begin
        phy_management_access[mahpmr_pkg::ACC_BUSY_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phy_data <= mahpmr_pkg::RST_DATA;
    end else if (ce) begin
      if (mg_state == mahpmr_pkg::MG_END && mg_read) begin
        phy_data <= rd_sr;
      end else if (wr && addr == mahpmr_pkg::OFF_DATA && mg_state == mahpmr_pkg::MG_IDLE) begin
        phy_data <= wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // management frame engine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mg_state  <= mahpmr_pkg::MG_IDLE;
      div_cnt   <= 2'h0;
      bit_cnt   <= 6'h00;
      frame_sr  <= '0;
      rd_sr     <= 16'h0000;
      mdc       <= 1'b0;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (ce) begin
      case (mg_state)
        mahpmr_pkg::MG_IDLE: begin
          mdc       <= 1'b0;
          mdio_oe_n <= 1'b1;
          if (acc_start) begin
            mg_state <= mahpmr_pkg::MG_RUN;
            div_cnt  <= 2'h0;
            bit_cnt  <= 6'h00;
            frame_sr <= {mahpmr_pkg::PREAMBLE, mahpmr_pkg::FR_START,
                         wdata[1] ? mahpmr_pkg::FR_OP_WR : mahpmr_pkg::FR_OP_RD,
                         wdata[15:11], wdata[10:6],
                         mahpmr_pkg::FR_TA_WR, phy_data};
          end
        end
        mahpmr_pkg::MG_RUN: begin
          div_cnt <= (div_cnt == mahpmr_pkg::DIV_LAST) ? 2'h0 : div_cnt + 2'h1;
          if (div_cnt == 2'h0) begin
            mdc       <= 1'b0;
            mdio_out  <= frame_sr[63];
            mdio_oe_n <= mg_read && bit_cnt >= mahpmr_pkg::BIT_TA;
          end
          if (div_cnt == mahpmr_pkg::DIV_HIGH) begin
            mdc <= 1'b1;
            if (mg_read && bit_cnt >= mahpmr_pkg::BIT_DATA) begin
              rd_sr <= {rd_sr[14:0], mdio_in};
            end
          end
          if (div_cnt == mahpmr_pkg::DIV_LAST) begin
            frame_sr <= {frame_sr[62:0], 1'b1};
            bit_cnt  <= bit_cnt + 6'h01;
            if (bit_cnt == mahpmr_pkg::BIT_LAST) begin
              mg_state <= mahpmr_pkg::MG_END;
            end
          end
        end
        mahpmr_pkg::MG_END: begin
          mdc       <= 1'b0;
          mdio_oe_n <= 1'b1;
          mdio_out  <= 1'b1;
          mg_state  <= mahpmr_pkg::MG_IDLE;
        end
        default: begin
          mg_state <= mahpmr_pkg::MG_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // receive address filter
  // ----------------------------------------------------------------------
  mahpmr_hash u_hash (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .rx_addr (rx_addr),
    .hash    (hash)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      filt <= '0;
    end else if (ce) begin
      filt.valid       <= hash.valid;
      filt.group       <= hash.octet[0][0];
      filt.station_hit <= hash.octet == {station_address_upper[15:0], station_address_lower};
      if (hash.octet[0][0]) begin
        filt.accept <= pass_all_group_frames
                       || (hash.index[5] ? multicast_hash_upper[hash.index[4:0]]
                                         : multicast_hash_lower[hash.index[4:0]]);
      end else begin
        filt.accept <= hash.octet == {station_address_upper[15:0], station_address_lower};
      end
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          mahpmr_pkg::OFF_CTRL:  rdata <= {30'h00000000, load_done, pass_all_group_frames};
          mahpmr_pkg::OFF_ADDRU: rdata <= station_address_upper;
          mahpmr_pkg::OFF_STATION_ADDRESS_LOWER: rdata <= station_address_lower;
          mahpmr_pkg::OFF_HASHU: rdata <= multicast_hash_upper;
          mahpmr_pkg::OFF_MULTICAST_HASH_LOWER: rdata <= multicast_hash_lower;
          mahpmr_pkg::OFF_ACC:   rdata <= phy_management_access;
          mahpmr_pkg::OFF_DATA:  rdata <= {16'h0000, phy_data};
          default:               rdata <= 32'h00000000;
        endcase
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  addr_reset_a: assert property (@(posedge clk) $fell(rst) |->
    station_address_upper == mahpmr_pkg::RST_ADDRU && station_address_lower == mahpmr_pkg::RST_STATION_ADDRESS_LOWER)
    else $error("station address reset value wrong");
  hash_reset_a: assert property (@(posedge clk) $fell(rst) |->
    multicast_hash_upper == 32'h00000000 && multicast_hash_lower == 32'h00000000)
    else $error("hash table reset value wrong");
  load_lower_a: assert property (@(posedge clk) disable iff (rst)
    ld_take && cfg_addr == mahpmr_pkg::CFG_FIRST |=> station_address_lower[7:0] == $past(cfg_data))
    else $error("first memory byte not in lower byte 0");
  load_upper_a: assert property (@(posedge clk) disable iff (rst)
    ld_take && cfg_addr == mahpmr_pkg::CFG_LAST |=> station_address_upper[15:8] == $past(cfg_data) && load_done)
    else $error("last memory byte not in upper byte 1");
  busy_hold_a: assert property (@(posedge clk) disable iff (rst)
    acc_start |=> phy_management_access[0] throughout (mg_state != mahpmr_pkg::MG_IDLE)[*8])
    else $error("busy dropped while access runs");
  busy_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && mg_state == mahpmr_pkg::MG_END |=> !phy_management_access[0] && mg_state == mahpmr_pkg::MG_IDLE)
    else $error("busy not cleared at access end");
  read_data_a: assert property (@(posedge clk) disable iff (rst)
    ce && mg_state == mahpmr_pkg::MG_END && mg_read |=> phy_data == $past(rd_sr))
    else $error("read result not stored at end");
  pass_all_a: assert property (@(posedge clk) disable iff (rst)
    ce && hash.valid && hash.octet[0][0] && pass_all_group_frames |=> filt.valid && filt.accept)
    else $error("group frame refused under pass all");
  // whole table as one word: index 0 is low bit 0, index 63 high bit 31
  logic [63:0] hash_table;
  assign hash_table = {multicast_hash_upper, multicast_hash_lower};
  hash_pick_a: assert property (@(posedge clk) disable iff (rst)
    ce && hash.valid && hash.octet[0][0] && !pass_all_group_frames
    |=> filt.accept == $past(hash_table[hash.index]))
    else $error("group accept not tied to indexed table bit");

endmodule

`default_nettype wire

// ---- mahpmr_pkg.sv ----
/*
  Shared constants and types for the station address, multicast hash
  and PHY management register block.
  Assumes a 10 MHz core clock and a register port indexed by word.
*/
`default_nettype none

package mahpmr_pkg;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL  = 4'h1;
  localparam logic [3:0] OFF_ADDRU = 4'h2;
  localparam logic [3:0] OFF_STATION_ADDRESS_LOWER = 4'h3;
  localparam logic [3:0] OFF_HASHU = 4'h4;
  localparam logic [3:0] OFF_MULTICAST_HASH_LOWER = 4'h5;
  localparam logic [3:0] OFF_ACC   = 4'h6;
  localparam logic [3:0] OFF_DATA  = 4'h7;

  // ----------------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_ADDRU = 32'h0000ffff;
  localparam logic [31:0] RST_STATION_ADDRESS_LOWER = 32'h0fffffff;
  localparam logic [31:0] RST_HASH  = 32'h00000000;
  localparam logic [31:0] RST_ACC   = 32'h00000000;
  localparam logic [15:0] RST_DATA  = 16'h0000;
  localparam int          CTRL_PASS_BIT = 0;
  localparam int          CTRL_DONE_BIT = 1;
  localparam int          ACC_PHY_LSB   = 11;
  localparam int          ACC_IDX_LSB   = 6;
  localparam int          ACC_DIR_BIT   = 1;
  localparam int          ACC_BUSY_BIT  = 0;

  // ----------------------------------------------------------------------
  // configuration memory byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFG_FIRST = 8'h01;
  localparam logic [7:0] CFG_UPPER = 8'h05;
  localparam logic [7:0] CFG_LAST  = 8'h06;

  // ----------------------------------------------------------------------
  // management frame timing and layout
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          MDC_PERIOD_NS = 400;
  localparam int          MDC_HALF      = (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  DIV_HIGH      = 2'(MDC_HALF);
  localparam logic [1:0]  DIV_LAST      = 2'(2 * MDC_HALF - 1);
  localparam logic [5:0]  BIT_TA        = 6'h2e;
  localparam logic [5:0]  BIT_DATA      = 6'h30;
  localparam logic [5:0]  BIT_LAST      = 6'h3f;
  localparam logic [31:0] PREAMBLE      = 32'hffffffff;
  localparam logic [1:0]  FR_START      = 2'h1;
  localparam logic [1:0]  FR_OP_WR      = 2'h1;
  localparam logic [1:0]  FR_OP_RD      = 2'h2;
  localparam logic [1:0]  FR_TA_WR      = 2'h2;

  // ----------------------------------------------------------------------
  // hash
  // ----------------------------------------------------------------------
  localparam logic [31:0] CRC_INIT  = 32'hffffffff;
  localparam logic [31:0] CRC_POLYR = 32'hedb88320;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic            valid;
    logic [5:0][7:0] octet;
  } mahpmr_rx_addr_type;

  typedef struct packed {
    logic            valid;
    logic [5:0]      index;
    logic [5:0][7:0] octet;
  } mahpmr_hash_type;

  typedef struct packed {
    logic valid;
    logic accept;
    logic group;
    logic station_hit;
  } mahpmr_filter_type;

  typedef enum logic [1:0] {LD_CHECK = 2'b00, LD_FETCH = 2'b01, LD_DONE = 2'b11} mahpmr_ld_state_type;
  typedef enum logic [1:0] {MG_IDLE = 2'b00, MG_RUN = 2'b01, MG_END = 2'b11} mahpmr_mg_state_type;

endpackage

`default_nettype wire

// ---- mahpmr_hash.sv ----
/*
  Hash index unit: folds a received destination address into the six
  bit multicast table index, one cycle after the address is offered.
  Assumes octet 0 is the first octet received, bits sent lsb first.
*/
`timescale 1ns/100ps
`default_nettype none

module mahpmr_hash (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire mahpmr_pkg::mahpmr_rx_addr_type rx_addr,
  output var  mahpmr_pkg::mahpmr_hash_type    hash
);

  // ----------------------------------------------------------------------
  // crc over the six octets
  // ----------------------------------------------------------------------
  function automatic logic [5:0] addr_index(input logic [5:0][7:0] oct);
    logic [31:0] crc;
    logic        fb;
    crc = mahpmr_pkg::CRC_INIT;
    fb  = 1'b0;
    for (int i = 0; i < 6; i++) begin
      for (int b = 0; b < 8; b++) begin
        fb  = crc[0] ^ oct[i][b];
        crc = (crc >> 1) ^ (fb ? mahpmr_pkg::CRC_POLYR : 32'h00000000);
      end
    end
    // upper six fcs bits, held reflected in the low end
    return {crc[0], crc[1], crc[2], crc[3], crc[4], crc[5]};
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      hash <= '0;
    end else if (ce) begin
      hash.valid <= rx_addr.valid;
      hash.octet <= rx_addr.octet;
      hash.index <= addr_index(rx_addr.octet);
    end
  end

endmodule

`default_nettype wire

// ---- mahpmr_far_model.sv ----
/*
  far-side model: configuration memory and management PHY.
  assumes one clock; the bench resolves the shared data pin.
*/
`timescale 1ns/100ps
`default_nettype none
module mahpmr_far_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        cfg_req,
  input  wire logic [7:0]  cfg_addr,
  output var  logic        cfg_ack,
  output var  logic [7:0]  cfg_data,
  input  wire logic        mdc,
  input  wire logic        mdio,
  output var  logic        phy_oe_n,
  output var  logic        phy_out,
  output var  logic [63:0] frame
);
  logic [1:0]  tick;
  logic        mdc_q;
  logic [5:0]  cnt;
  logic [63:0] sr;
  logic        rd_op;
  logic [4:0]  ridx;
  logic [15:0] rd_val;
  // answers every cycle, or every fourth when slow
  assign cfg_ack  = cfg_req && (!slow || tick == 2'h3);
  // idle data lines show the inverse pattern
  assign cfg_data = cfg_ack ? {cfg_addr[3:0], 4'h2} : ~{cfg_addr[3:0], 4'h2};
  assign rd_val   = {8'hc3, 3'h0, ridx};
  // turnaround low, then read data msb first
  assign phy_oe_n = !(rd_op && cnt >= 6'd47);
  assign phy_out  = (cnt == 6'd47) ? 1'b0 : rd_val[4'(6'd63 - cnt)];
  always_ff @(posedge clk) begin
    tick  <= rst ? 2'h0 : tick + 2'h1;
    mdc_q <= rst ? 1'b0 : mdc;
    if (rst) begin
      cnt   <= 6'h00;
      rd_op <= 1'b0;
    end else if (mdc && !mdc_q) begin
      sr  <= {sr[62:0], mdio};
      cnt <= cnt + 6'h01;
      if (cnt == 6'd35) rd_op <= ({sr[0], mdio} == 2'b10);
      if (cnt == 6'd45) ridx <= {sr[3:0], mdio};
      if (cnt == 6'd63) frame <= {sr[62:0], mdio};
    end
  end
endmodule
`default_nettype wire

// ---- mac_addr_hash_phy_mgmt_regs_bench.sv ----
/*
  bench for the address, hash and PHY management registers.
  assumes the far-side model answers memory and PHY traffic.
*/
`timescale 1ns/100ps
`default_nettype none
module mac_addr_hash_phy_mgmt_regs_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        cfg_present = 1'b0;
  logic        slow = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        cfg_req, cfg_ack, load_done, mdc, mdio_out, mdio_oe_n, phy_oe_n, phy_out, mdio;
  logic [7:0]  cfg_addr, cfg_data;
  logic [63:0] frame;
  mahpmr_pkg::mahpmr_rx_addr_type rx_addr = '0;
  mahpmr_pkg::mahpmr_filter_type  filt;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  // pulled-up shared data pin
  assign mdio = !mdio_oe_n ? mdio_out : !phy_oe_n ? phy_out : 1'b1;
  mahpmr_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cfg_present(cfg_present), .cfg_req(cfg_req), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack),
    .cfg_data(cfg_data), .load_done(load_done), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .rx_addr(rx_addr), .filt(filt));
  mahpmr_far_model far_u (.clk(clk), .rst(rst), .slow(slow), .cfg_req(cfg_req), .cfg_addr(cfg_addr),
    .cfg_ack(cfg_ack), .cfg_data(cfg_data), .mdc(mdc), .mdio(mdio), .phy_oe_n(phy_oe_n),
    .phy_out(phy_out), .frame(frame));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(name, {32'h0, exp}, {32'h0, d});
  endtask
  task automatic reset_dut(input logic present, input logic s);
    int i;
    @(posedge clk);
    rst         <= 1'b1;
    cfg_present <= present;
    slow        <= s;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 100 && load_done !== 1'b1; i++) @(posedge clk);
    chk("load_done", 64'h1, {63'h0, load_done});
  endtask
  task automatic wait_idle();
    logic [31:0] v;
    int i;
    rd_reg(mahpmr_pkg::OFF_ACC, v);
    chk("busy_set", 64'h1, {63'h0, v[0]});
    for (i = 0; i < 300 && v[0] !== 1'b0; i++) rd_reg(mahpmr_pkg::OFF_ACC, v);
    chk("busy_clr", 64'h0, {63'h0, v[0]});
  endtask
  task automatic filt_chk(input logic [47:0] oct, input logic [3:0] exp);
    int i;
    @(posedge clk);
    rx_addr <= {1'b1, oct};
    @(posedge clk);
    rx_addr.valid <= 1'b0;
    i = 0;
    while (i < 4 && filt.valid !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("filt", {60'h0, exp}, {60'h0, filt});
  endtask
  task automatic t_reset_vals();
    reset_dut(1'b0, 1'b0);
    rd_chk("upper", mahpmr_pkg::OFF_ADDRU, 32'h0000ffff);
    rd_chk("lower", mahpmr_pkg::OFF_STATION_ADDRESS_LOWER, 32'h0fffffff);
    rd_chk("hash_hi", mahpmr_pkg::OFF_HASHU, 32'h0);
    rd_chk("hash_lo", mahpmr_pkg::OFF_MULTICAST_HASH_LOWER, 32'h0);
    rd_chk("access", mahpmr_pkg::OFF_ACC, 32'h0);
    rd_chk("data", mahpmr_pkg::OFF_DATA, 32'h0);
    rd_chk("unmapped", 4'hf, 32'h0);
    wr_reg(mahpmr_pkg::OFF_ADDRU, 32'hffffa5a5);
    rd_chk("upper_wr", mahpmr_pkg::OFF_ADDRU, 32'h0000a5a5);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(mahpmr_pkg::OFF_HASHU, 32'hffffffff);
    ce <= 1'b1;
    rd_chk("hash_frozen", mahpmr_pkg::OFF_HASHU, 32'h0);
  endtask
  task automatic t_load_filter();
    reset_dut(1'b1, 1'b1);
    rd_chk("lower_ld", mahpmr_pkg::OFF_STATION_ADDRESS_LOWER, 32'h42322212);
    rd_chk("upper_ld", mahpmr_pkg::OFF_ADDRU, 32'h00006252);
    filt_chk(48'h625242322212, 4'b1101);
    filt_chk(48'h615242322212, 4'b1000);
    filt_chk(48'h0000005e0001, 4'b1010);
    wr_reg(mahpmr_pkg::OFF_HASHU, 32'hffffffff);
    wr_reg(mahpmr_pkg::OFF_MULTICAST_HASH_LOWER, 32'hffffffff);
    filt_chk(48'h0000005e0001, 4'b1110);
    wr_reg(mahpmr_pkg::OFF_HASHU, 32'h0);
    wr_reg(mahpmr_pkg::OFF_MULTICAST_HASH_LOWER, 32'h0);
    wr_reg(mahpmr_pkg::OFF_CTRL, 32'h1);
    filt_chk(48'h0000005e0001, 4'b1110);
    wr_reg(mahpmr_pkg::OFF_CTRL, 32'h0);
  endtask
  task automatic t_phy();
    reset_dut(1'b1, 1'b0);
    rd_chk("lower_fast", mahpmr_pkg::OFF_STATION_ADDRESS_LOWER, 32'h42322212);
    wr_reg(mahpmr_pkg::OFF_DATA, 32'h0000beef);
    wr_reg(mahpmr_pkg::OFF_ACC, 32'h00000943);
    wr_reg(mahpmr_pkg::OFF_DATA, 32'h00001234);
    wait_idle();
    chk("wr_frame", {32'hffffffff, 4'b0101, 5'h01, 5'h05, 2'b10, 16'hbeef}, frame);
    wr_reg(mahpmr_pkg::OFF_ACC, 32'h00000a41);
    wait_idle();
    rd_chk("rd_data", mahpmr_pkg::OFF_DATA, 32'h0000c309);
    chk("rd_frame", {32'hffffffff, 4'b0110, 5'h01, 5'h09, 2'b10, 16'hc309}, frame);
  endtask
  initial begin
    t_reset_vals();
    t_load_filter();
    t_phy();
    end_of_test();
  end
endmodule
`default_nettype wire
